// >>> lert_defines.vh
`ifndef LERT_DEFINES_VH
`define LERT_DEFINES_VH

// register byte offsets
`define LERT_OFF_CTRL        12'h000
`define LERT_OFF_STATUS      12'h004
`define LERT_OFF_RXDATA      12'h008

// control register fields
`define LERT_CTRL_ENABLE     0
`define LERT_CTRL_RELEASE    1
`define LERT_CTRL_RESET      1'b0

// status register fields
`define LERT_ST_DIR          0
`define LERT_ST_LPDT         1
`define LERT_ST_ULPS         2
`define LERT_ST_TRIG_LO      4
`define LERT_ST_TRIG_HI      7
`define LERT_ST_ESCAPE       8

// receive data register fields
`define LERT_RX_BYTE_LO      0
`define LERT_RX_BYTE_HI      7
`define LERT_RX_CNT_LO       16
`define LERT_RX_CNT_HI       23

// lane direction codes and reset value
`define LERT_DIR_TRANSMIT    1'b0
`define LERT_DIR_RECEIVE     1'b1
`define LERT_DIR_RESET       1'b0

// low-power line codes {dp, dn}
`define LERT_LINE_STOP       2'b11
`define LERT_LINE_P          2'b10
`define LERT_LINE_N          2'b01
`define LERT_LINE_SPACE      2'b00

// escape entry command codes, first received bit in bit 0
`define LERT_CMD_LPDT        8'hE1
`define LERT_CMD_ULPS        8'h1E
`define LERT_CMD_TRIG0       8'h62
`define LERT_CMD_TRIG1       8'h5D
`define LERT_CMD_TRIG2       8'h21
`define LERT_CMD_TRIG3       8'h12

// index of the last bit in one command or data byte
`define LERT_BITS_LAST       3'h7

`endif

// >>> lert_sync.v
`timescale 1ns/1ps
module lert_sync #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage is read only by the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // lert_sync

// >>> lert_top.v
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lert_defines.vh"

// What this block does
// [RL1] the receive clock output is recovered from the two low-power line levels
// [RL2] low-power data receive indication stays high until stop state on the lines
// [RL3] in data receive mode each received byte is presented with receive valid
// [RL4] ultra-low-power indication stays high from entry until stop state
// [RL5] each received trigger sets its own flag bit, held until stop state
// [RL6] received bytes are eight bits, bit 0 the earliest on the line
// [RL7] a byte is handed over on a rising edge of the recovered receive clock
// [RL8] the protocol captures the byte at each receive clock rise with valid high
// [RL9] the protocol keeps up with receive data, there is no throttling
// [RL10] the protocol raises the reverse request to hand the lane to the far side
// [RL11] the reverse request is sampled only on rising transmit escape clock edges
// [RL12] the reverse request acts only while transmitting, ignored while receiving
// [RL13] the direction output shows 0 for transmit and 1 for receive
// [RL14] the transmit escape clock synchronises the reverse request and is always present
// [RL15] with the lane disabled inputs are ignored and outputs sit inactive, except the receive byte, which keeps its last value
// [RL16] one receive indication per escape entry, all cleared together at stop
// [RL17] receive valid stays low while data receive indication is low
module lert_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        line_dp,
  input  wire        line_dn,
  input  wire        escape_transmit_clock,
  input  wire        lane_reverse_request,
  output wire        escape_receive_clock,
  output wire        lowpower_data_receive_active,
  output wire        ultra_lowpower_receive_active,
  output wire [3:0]  received_trigger_flags,
  output wire [7:0]  escape_receive_byte,
  output wire        escape_receive_valid,
  output wire        lane_direction
);

  localparam [8:0] ST_STOP = 9'h001;
  localparam [8:0] ST_E1   = 9'h002;
  localparam [8:0] ST_E2   = 9'h004;
  localparam [8:0] ST_E3   = 9'h008;
  localparam [8:0] ST_CMD  = 9'h010;
  localparam [8:0] ST_LPDT = 9'h020;
  localparam [8:0] ST_ULPS = 9'h040;
  localparam [8:0] ST_TRIG = 9'h080;
  localparam [8:0] ST_WAIT = 9'h100;

  localparam [1:0] KIND_NONE = 2'h0;
  localparam [1:0] KIND_LPDT = 2'h1;
  localparam [1:0] KIND_ULPS = 2'h2;
  localparam [1:0] KIND_TRIG = 2'h3;

  wire [3:0] sync_w;
  wire [1:0] line_s;
  wire       txclk_s;
  wire       req_s;
  wire       line_chg;
  wire       line_mark;
  wire       mark_bit;
  wire [7:0] shifted;
  wire       txclk_rise;
  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;

  reg [8:0]  state_q;
  reg [8:0]  state_d;
  reg [1:0]  line_prev_q;
  reg [7:0]  shift_q;
  reg [7:0]  shift_d;
  reg [2:0]  cnt_q;
  reg [2:0]  cnt_d;
  reg        lpdt_q;
  reg        lpdt_d;
  reg        ulps_q;
  reg        ulps_d;
  reg [3:0]  trig_q;
  reg [3:0]  trig_d;
  reg [7:0]  byte_q;
  reg [7:0]  byte_d;
  reg        valid_q;
  reg        valid_d;
  reg        byte_done;
  reg        x1_q;
  reg        rxclk_q;
  reg        txclk_prev_q;
  reg        dir_q;
  reg        enable_q;
  reg        release_q;
  reg [7:0]  byte_cnt_q;
  reg [31:0] status_w;
  reg [31:0] rxdata_w;

  // line levels, transmit escape clock and request all come from outside pclk
  lert_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({line_dp, line_dn, escape_transmit_clock, lane_reverse_request}),
    .sync_out (sync_w)
  );

  assign line_s  = sync_w[3:2];
  assign txclk_s = sync_w[1];
  assign req_s   = sync_w[0];

  assign line_chg  = (line_s != line_prev_q);
  assign line_mark = line_chg && ((line_s == `LERT_LINE_P) || (line_s == `LERT_LINE_N));
  assign mark_bit  = (line_s == `LERT_LINE_P);
  // first received bit ends up in bit 0
  assign shifted   = {mark_bit, shift_q[7:1]}; // RL6

  // classify a completed escape entry command
  function [1:0] cmd_kind;
    input [7:0] c;
    begin
      case (c)
        `LERT_CMD_LPDT:  cmd_kind = KIND_LPDT;
        `LERT_CMD_ULPS:  cmd_kind = KIND_ULPS;
        `LERT_CMD_TRIG0: cmd_kind = KIND_TRIG;
        `LERT_CMD_TRIG1: cmd_kind = KIND_TRIG;
        `LERT_CMD_TRIG2: cmd_kind = KIND_TRIG;
        `LERT_CMD_TRIG3: cmd_kind = KIND_TRIG;
        default:         cmd_kind = KIND_NONE;
      endcase
    end
  endfunction

  // which trigger flag a trigger command selects
  function [3:0] cmd_trigger;
    input [7:0] c;
    begin
      case (c)
        `LERT_CMD_TRIG0: cmd_trigger = 4'h1;
        `LERT_CMD_TRIG1: cmd_trigger = 4'h2;
        `LERT_CMD_TRIG2: cmd_trigger = 4'h4;
        `LERT_CMD_TRIG3: cmd_trigger = 4'h8;
        default:         cmd_trigger = 4'h0;
      endcase
    end
  endfunction

  // escape receive sequencer
  always @* begin
    state_d   = state_q;
    shift_d   = shift_q;
    cnt_d     = cnt_q;
    lpdt_d    = lpdt_q;
    ulps_d    = ulps_q;
    trig_d    = trig_q;
    byte_d    = byte_q;
    valid_d   = valid_q;
    byte_done = 1'b0;
    if (!enable_q) begin
      state_d = ST_STOP; // RL15
      cnt_d   = 3'h0;
      lpdt_d  = 1'b0;
      ulps_d  = 1'b0;
      trig_d  = 4'h0;
      valid_d = 1'b0;
    end else if (line_s == `LERT_LINE_STOP) begin
      // stop state ends every escape mode at once
      state_d = ST_STOP; // RL16
      cnt_d   = 3'h0;
      lpdt_d  = 1'b0; // RL2
      ulps_d  = 1'b0; // RL4
      trig_d  = 4'h0; // RL5
      valid_d = 1'b0; // RL17
    end else if (line_chg) begin
      case (state_q)
        ST_STOP: begin
          if (line_s == `LERT_LINE_P) begin
            state_d = ST_E1;
          end else begin
            state_d = ST_WAIT;
          end
        end
        ST_E1: begin
          if (line_s == `LERT_LINE_SPACE) begin
            state_d = ST_E2;
          end else begin
            state_d = ST_WAIT;
          end
        end
        ST_E2: begin
          if (line_s == `LERT_LINE_N) begin
            state_d = ST_E3;
          end else begin
            state_d = ST_WAIT;
          end
        end
        ST_E3: begin
          if (line_s == `LERT_LINE_SPACE) begin
            state_d = ST_CMD;
            cnt_d   = 3'h0;
          end else begin
            state_d = ST_WAIT;
          end
        end
        ST_CMD: begin
          if (line_mark) begin
            shift_d = shifted;
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == `LERT_BITS_LAST) begin
              // only one indication is raised per entry
              case (cmd_kind(shifted)) // RL16
                KIND_LPDT: begin
                  state_d = ST_LPDT;
                  lpdt_d  = 1'b1; // RL2
                end
                KIND_ULPS: begin
                  state_d = ST_ULPS;
                  ulps_d  = 1'b1; // RL4
                end
                KIND_TRIG: begin
                  state_d = ST_TRIG;
                  trig_d  = cmd_trigger(shifted); // RL5
                end
                default: begin
                  state_d = ST_WAIT;
                end
              endcase
            end
          end
        end
        ST_LPDT: begin
          if (line_mark) begin
            // valid covers a single receive clock rise only
            valid_d = 1'b0; // RL3
            shift_d = shifted;
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == `LERT_BITS_LAST) begin
              byte_d    = shifted; // RL6
              valid_d   = 1'b1; // RL3
              byte_done = 1'b1;
            end
          end
        end
        ST_ULPS: begin
          state_d = ST_ULPS;
        end
        ST_TRIG: begin
          state_d = ST_TRIG;
        end
        ST_WAIT: begin
          state_d = ST_WAIT;
        end
        default: begin
          state_d = ST_WAIT;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_STOP;
      line_prev_q <= `LERT_LINE_STOP;
      shift_q     <= 8'h00;
      cnt_q       <= 3'h0;
      lpdt_q      <= 1'b0;
      ulps_q      <= 1'b0;
      trig_q      <= 4'h0;
      byte_q      <= 8'h00;
      valid_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      line_prev_q <= line_s;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      lpdt_q      <= lpdt_d;
      ulps_q      <= ulps_d;
      trig_q      <= trig_d;
      byte_q      <= byte_d;
      valid_q     <= valid_d;
    end
  end

  // recovered clock is the xor of the lines, one cycle behind the data so the
  // byte and valid are settled before its rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1_q    <= 1'b0;
      rxclk_q <= 1'b0;
    end else begin
      x1_q    <= enable_q & (line_s[1] ^ line_s[0]); // RL1
      rxclk_q <= x1_q; // RL7
    end
  end

  assign txclk_rise = txclk_s & ~txclk_prev_q;

  // lane direction: reverse request taken on transmit escape clock rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txclk_prev_q <= 1'b0;
      dir_q        <= `LERT_DIR_RESET;
    end else begin
      txclk_prev_q <= txclk_s;
      if (!enable_q) begin
        dir_q <= `LERT_DIR_RESET; // RL15
      end else if (txclk_rise && req_s && (dir_q == `LERT_DIR_TRANSMIT)) begin
        dir_q <= `LERT_DIR_RECEIVE; // RL11 RL12 RL14
      end else if (release_q) begin
        dir_q <= `LERT_DIR_TRANSMIT;
      end
    end
  end

  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `LERT_OFF_CTRL) || (paddr == `LERT_OFF_STATUS) ||
                   (paddr == `LERT_OFF_RXDATA);
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q   <= `LERT_CTRL_RESET;
      release_q  <= 1'b0;
      byte_cnt_q <= 8'h00;
    end else begin
      release_q <= 1'b0;
      if (wr_en && (paddr == `LERT_OFF_CTRL) && pstrb[0]) begin
        enable_q  <= pwdata[`LERT_CTRL_ENABLE];
        release_q <= pwdata[`LERT_CTRL_RELEASE];
      end
      // a byte arriving with the clearing write is still counted
      if (wr_en && (paddr == `LERT_OFF_RXDATA) && pstrb[2]) begin
        byte_cnt_q <= {7'h00, byte_done};
      end else if (byte_done) begin
        byte_cnt_q <= byte_cnt_q + 8'h01;
      end
    end
  end

  always @* begin
    status_w = 32'h00000000;
    status_w[`LERT_ST_DIR]                       = dir_q;
    status_w[`LERT_ST_LPDT]                      = lpdt_q;
    status_w[`LERT_ST_ULPS]                      = ulps_q;
    status_w[`LERT_ST_TRIG_HI:`LERT_ST_TRIG_LO]  = trig_q;
    status_w[`LERT_ST_ESCAPE]                    = ~state_q[0];
    rxdata_w = 32'h00000000;
    rxdata_w[`LERT_RX_BYTE_HI:`LERT_RX_BYTE_LO]  = byte_q;
    rxdata_w[`LERT_RX_CNT_HI:`LERT_RX_CNT_LO]    = byte_cnt_q;
  end

  // read data registered in the setup cycle, ready for the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en && !penable) begin
        case (paddr)
          `LERT_OFF_CTRL:   prdata <= {30'h00000000, 1'b0, enable_q};
          `LERT_OFF_STATUS: prdata <= status_w;
          `LERT_OFF_RXDATA: prdata <= rxdata_w;
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign escape_receive_clock          = rxclk_q;
  assign lowpower_data_receive_active  = lpdt_q;
  assign ultra_lowpower_receive_active = ulps_q;
  assign received_trigger_flags        = trig_q;
  assign escape_receive_byte           = byte_q;
  assign escape_receive_valid          = valid_q & lpdt_q; // RL17
  assign lane_direction                = dir_q; // RL13

endmodule // lert_top

// >>> lert_props.sv
`timescale 1ns/1ps
module lert_props (
  input wire        pclk,
  input wire        presetn,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        line_dp,
  input wire        line_dn,
  input wire        escape_transmit_clock,
  input wire        lane_reverse_request,
  input wire        escape_receive_clock,
  input wire        lowpower_data_receive_active,
  input wire        ultra_lowpower_receive_active,
  input wire [3:0]  received_trigger_flags,
  input wire        escape_receive_valid,
  input wire        lane_direction
);
  logic en_q;
  wire  ctrl_wr = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
  wire  any_ind = lowpower_data_receive_active || ultra_lowpower_receive_active
                  || (|received_trigger_flags);
  // shadow of the lane enable bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_q <= 1'b0;
    else if (ctrl_wr) en_q <= pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_valid_needs_lpdt: assert property (escape_receive_valid |-> lowpower_data_receive_active)
    else $error("receive valid outside data receive");
  chk_one_indication: assert property ($onehot0({lowpower_data_receive_active,
    ultra_lowpower_receive_active, received_trigger_flags})) else $error("two indications");
  chk_stop_clears: assert property ((line_dp && line_dn)[*4] |-> !any_ind)
    else $error("indication survives stop");
  chk_held_to_stop: assert property ($fell(any_ind) |-> $past(line_dp && line_dn, 3) || !en_q)
    else $error("indication dropped without stop");
  chk_disabled_quiet: assert property ((!en_q)[*4] |-> !any_ind && !escape_receive_clock
    && !escape_receive_valid && !lane_direction) else $error("output active while disabled");
  chk_clock_lines: assert property (en_q && $past(en_q, 5)
    |-> escape_receive_clock == $past(line_dp ^ line_dn, 4)) else $error("receive clock off");
  chk_byte_rise: assert property ($rose(escape_receive_valid) |=> $rose(escape_receive_clock))
    else $error("byte not followed by clock rise");
  chk_valid_span: assert property ($fell(escape_receive_valid) && lowpower_data_receive_active
    |=> $rose(escape_receive_clock)) else $error("valid dropped before mark");
  chk_turn_taken: assert property ($rose(escape_transmit_clock) && lane_reverse_request
    && !lane_direction && en_q |-> ##3 lane_direction) else $error("turn request lost");
  chk_turn_edge: assert property ($rose(lane_direction) |-> $past(escape_transmit_clock, 3)
    && !$past(escape_transmit_clock, 4)) else $error("turn off the tx clock rise");
  chk_dir_holds: assert property ($fell(lane_direction) |-> $past(ctrl_wr && pwdata[1], 2) || !en_q)
    else $error("direction fell by itself");
  cov_byte: cover property ($rose(escape_receive_valid));
  cov_turn: cover property ($rose(lane_direction));
  cov_trig: cover property (|received_trigger_flags);
endmodule // lert_props

bind lert_top lert_props i_lert_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .line_dp(line_dp), .line_dn(line_dn), .escape_transmit_clock(escape_transmit_clock),
  .lane_reverse_request(lane_reverse_request), .escape_receive_clock(escape_receive_clock),
  .lowpower_data_receive_active(lowpower_data_receive_active),
  .ultra_lowpower_receive_active(ultra_lowpower_receive_active),
  .received_trigger_flags(received_trigger_flags),
  .escape_receive_valid(escape_receive_valid), .lane_direction(lane_direction));

// >>> lert_proto_model.sv
`timescale 1ns/1ps
module lert_proto_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       turn_want,
  input  wire       escape_receive_clock,
  input  wire       escape_receive_valid,
  input  wire [7:0] escape_receive_byte,
  output logic      escape_transmit_clock,
  output logic      lane_reverse_request
);
  logic [7:0] got [0:7];
  int         n_got = 0;
  int         tick;
  // tx escape clock runs free at six pclk; request moves on its falling edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 0;
      escape_transmit_clock <= 1'b0;
      lane_reverse_request <= 1'b0;
    end else begin
      tick <= (tick == 2) ? 0 : tick + 1;
      if (tick == 2) begin
        escape_transmit_clock <= !escape_transmit_clock;
        if (escape_transmit_clock)
          lane_reverse_request <= turn_want;
      end
    end
  end
  // no ready handshake: every valid byte at a clock rise is taken
  always @(posedge escape_receive_clock) begin
    if (escape_receive_valid === 1'b1) begin
      got[n_got % 8] <= escape_receive_byte;
      n_got <= n_got + 1;
    end
  end
endmodule // lert_proto_model

// >>> lert_top_bench.sv
`timescale 1ns/1ps
`include "lert_defines.vh"
`define CHK(nm, exp, act) begin samples_checked++; if ((act) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, exp, act); end end
module lert_top_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, line_dp, line_dn, turn_want, err;
  logic [31:0] pwdata, rd;
  logic [3:0]  pstrb;
  wire  [31:0] prdata;
  wire  [7:0]  rx_byte;
  wire  [3:0]  trig_flags;
  wire         pready, pslverr, tx_clk, turn_req, rx_clk, lpdt, ulps, rx_valid, dir;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [7:0]  trig_cmd [0:3] = '{`LERT_CMD_TRIG0, `LERT_CMD_TRIG1, `LERT_CMD_TRIG2,
                                  `LERT_CMD_TRIG3};
  always #20 pclk = !pclk;
  lert_top i_lert_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_dp(line_dp), .line_dn(line_dn),
    .escape_transmit_clock(tx_clk), .lane_reverse_request(turn_req),
    .escape_receive_clock(rx_clk), .lowpower_data_receive_active(lpdt),
    .ultra_lowpower_receive_active(ulps), .received_trigger_flags(trig_flags),
    .escape_receive_byte(rx_byte), .escape_receive_valid(rx_valid), .lane_direction(dir));
  lert_proto_model i_lert_proto_model (.pclk(pclk), .presetn(presetn), .turn_want(turn_want),
    .escape_receive_clock(rx_clk), .escape_receive_valid(rx_valid),
    .escape_receive_byte(rx_byte), .escape_transmit_clock(tx_clk),
    .lane_reverse_request(turn_req));
  task stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chkreg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask
  // each line level is held four pclk
  task ln(input logic [1:0] v);
    line_dp <= v[1];
    line_dn <= v[0];
    repeat (4) @(posedge pclk);
  endtask
  task bits(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      ln(b[i] ? 2'b10 : 2'b01);
      ln(2'b00);
    end
  endtask
  task esc(input logic [7:0] cmd);
    ln(2'b10);
    ln(2'b00);
    ln(2'b01);
    ln(2'b00);
    bits(cmd);
  endtask
  task turn;
    turn_want <= 1'b1;
    repeat (20) @(posedge pclk);
    turn_want <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    paddr = 12'h000;
    {psel, penable, pwrite, turn_want} = 4'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    {line_dp, line_dn} = 2'h3;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chkreg(12'h004, 32'h1FF, 32'h0, "status reset");
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped read", 32'h0, rd)
    esc(`LERT_CMD_ULPS);
    chkreg(12'h004, 32'hFF, 32'h0, "status disabled");
    ln(2'b11);
    $display("test reset and disable done");
    apb(1'b1, 12'h000, 32'h1);
    esc(`LERT_CMD_LPDT);
    chkreg(12'h004, 32'hFF, 32'h2, "data receive status");
    `CHK("data receive pin", 1'b1, lpdt)
    bits(8'hA5);
    bits(8'h3C);
    `CHK("first byte", 8'hA5, i_lert_proto_model.got[0])
    `CHK("second byte", 8'h3C, i_lert_proto_model.got[1])
    `CHK("byte count", 2, i_lert_proto_model.n_got)
    chkreg(12'h008, 32'hFF00FF, 32'h2003C, "receive data");
    ln(2'b11);
    chkreg(12'h004, 32'hFF, 32'h0, "stop clears data");
    $display("test data receive done");
    for (int i = 0; i < 4; i++) begin
      esc(trig_cmd[i]);
      chkreg(12'h004, 32'hFF, 32'h10 << i, "trigger status");
      `CHK("trigger pins", 4'h1 << i, trig_flags)
      ln(2'b11);
    end
    $display("test triggers done");
    esc(`LERT_CMD_ULPS);
    chkreg(12'h004, 32'hFF, 32'h4, "ulps status");
    `CHK("ulps pin", 1'b1, ulps)
    turn;
    chkreg(12'h004, 32'hFF, 32'h5, "turned to receive");
    `CHK("direction pin", 1'b1, dir)
    apb(1'b1, 12'h000, 32'h3);
    chkreg(12'h004, 32'hFF, 32'h4, "back to transmit");
    turn;
    chkreg(12'h004, 32'hFF, 32'h5, "second turn");
    apb(1'b1, 12'h000, 32'h0);
    repeat (4) @(posedge pclk);
    chkreg(12'h004, 32'hFF, 32'h0, "disable clears");
    ln(2'b11);
    $display("test turnaround and disable done");
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end
endmodule // lert_top_bench
